// ===== logic/swc_defines.svh
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH
// ==========================================
// register byte offsets
`define SWC_CTRL_OFS 5'h00
`define SWC_WAKE_EN_OFS 5'h04
`define SWC_FLAGS_OFS 5'h08
`define SWC_SRC_CFG_OFS 5'h0C
`define SWC_EVT_OFS 5'h10
`define SWC_MASK_OFS 5'h14
// ==========================================
// field positions
`define SWC_CTRL_GIE 0
`define SWC_CTRL_WDT_EN 1
`define SWC_CTRL_XTAL 2
`define SWC_CFG_T1_ASYNC 0
`define SWC_CFG_ADC_RC 1
`define SWC_EVT_WAKE_RST 0
`define SWC_EVT_WAKE_WDT 1
`define SWC_EVT_WAKE_INT 2
`define SWC_EVT_SLEEP_NOP 3
`define SWC_EVT_SLEPT 4
// ==========================================
// widths and reset values
`define SWC_NSRC 9
`define SWC_NEVT 5
`define SWC_PC_W 13
`define SWC_CTRL_RST 3'h0
`define SWC_WAKE_EN_RST 9'h000
`define SWC_SRC_CFG_RST 2'h0
`define SWC_VECTOR_ADDR 13'h0004
// ==========================================
// timing: start-up wait in oscillator periods
`define SWC_OST_TOSC 1024
`define SWC_OSC_PERIOD_NS 4
`define SWC_CLK_PERIOD_NS 4
`define SWC_OST_CYCLES ((`SWC_OST_TOSC * `SWC_OSC_PERIOD_NS + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
`define SWC_OST_W 11
`endif

// ===== logic/swc_pkg.sv
package swc_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_ASLEEP,
        SWC_STARTUP,
        SWC_RESUME
    } swc_state_t;

    // wake-capable interrupt flags, one bit per source
    typedef struct packed {
        logic twowire_slave;
        logic serial_break;
        logic edge_pin;
        logic port_change;
        logic comparator;
        logic nvm_write;
        logic conversion;
        logic capture;
        logic timer_one;
    } swc_src_t;

    // why the last sleep ended
    typedef enum logic [1:0] {
        SWC_CAUSE_NONE,
        SWC_CAUSE_RESET,
        SWC_CAUSE_WDT,
        SWC_CAUSE_INT
    } swc_cause_t;
endpackage

// ===== logic/swc_sync.sv
`timescale 1ns/1ns
// ==========================================
// two-stage synchroniser for asynchronous levels
module swc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // first stage, read only by the second
    logic [W-1:0] meta_r;

    // both stages reset to the idle level of the source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // swc_sync

// ===== logic/swc_ost_timer.sv
`timescale 1ns/1ns
`include "swc_defines.svh"
// ==========================================
// oscillator start-up wait counter
module swc_ost_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic done
);
    localparam logic [`SWC_OST_W-1:0] LAST = `SWC_OST_W'(`SWC_OST_CYCLES - 1);
    logic [`SWC_OST_W-1:0] cnt_r; // cycles waited so far
    logic busy_r; // wait in progress

    // count from start; done pulses on the last cycle of the wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_r <= '0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r + `SWC_OST_W'(1);
                if (cnt_r == LAST - `SWC_OST_W'(1)) begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // swc_ost_timer

// ===== logic/swc_sleep_wakeup.sv
`timescale 1ns/1ns
`include "swc_defines.svh"
module swc_sleep_wakeup
    import swc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and asynchronous sources
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire swc_src_t src_flags,
    // instruction sequencer, same clock
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic [`SWC_PC_W-1:0] pc,
    // outputs
    output logic [`SWC_PC_W-1:0] prefetch_addr,
    output logic prefetch_req,
    output logic watchdog_clear,
    output logic device_reset,
    output logic clk_run,
    output logic osc_drive,
    output logic port_hold,
    output logic resume,
    output logic vector_branch,
    output logic [`SWC_PC_W-1:0] vector_addr,
    output logic time_out_flag,
    output logic power_down_flag,
    output logic irq
);
    // ==========================================
    // declarations
    swc_state_t state_r; // sleep sequencer state
    swc_cause_t cause_r; // source of the current wake
    logic [2:0] ctrl_r; // gie, watchdog enable, crystal mode
    logic [`SWC_NSRC-1:0] wake_en_r; // per-source enables
    logic [1:0] src_cfg_r; // timer async, rc conversion clock
    logic [`SWC_NEVT-1:0] evt_r; // sticky event bits
    logic [`SWC_NEVT-1:0] mask_r; // event interrupt mask
    logic [`SWC_NEVT-1:0] evt_set; // events this cycle
    logic rst_pin_n_s; // synchronised reset pin
    logic wdt_to_s; // synchronised watchdog time-out
    logic [`SWC_NSRC-1:0] src_s; // synchronised source flags
    logic [`SWC_NSRC-1:0] qual; // sources allowed to wake
    logic int_pend; // an enabled source is pending
    logic ost_start; // begin start-up wait
    logic ost_done; // start-up wait finished
    logic aw_got_r; // write address held
    logic w_got_r; // write data held
    logic [4:0] awaddr_r; // held write address
    logic [31:0] wdata_r; // held write data
    logic [3:0] wstrb_r; // held strobes

    // byte-lane merge, used by every writable register except the event word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================
    // synchronisers: everything here may toggle while clocks are stopped
    // asynchronous wake detect
    swc_sync #(.W(1), .INIT(1'b1)) u_sync_rst (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(external_reset_pin_n),
        .q(rst_pin_n_s)
    );
    swc_sync #(.W(1 + `SWC_NSRC), .INIT('0)) u_sync_src (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({watchdog_timeout, src_flags}),
        .q({wdt_to_s, src_s})
    );

    // ==========================================
    // wake qualification
    // timer and conversion need their own clocks running in sleep
    // clocked sources gated
    always_comb begin
        qual = src_s & wake_en_r;
        if (!src_cfg_r[`SWC_CFG_T1_ASYNC]) begin
            qual[0] = 1'b0;
        end
        if (!src_cfg_r[`SWC_CFG_ADC_RC]) begin
            qual[2] = 1'b0;
        end
    end
    assign int_pend = |qual;

    // ==========================================
    // start-up wait
    // crystal start-up delay
    assign ost_start = (state_r == SWC_ASLEEP) && (!rst_pin_n_s || int_pend ||
        (wdt_to_s && ctrl_r[`SWC_CTRL_WDT_EN])) && ctrl_r[`SWC_CTRL_XTAL];
    swc_ost_timer u_ost (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(ost_start),
        .done(ost_done)
    );

    // ==========================================
    // sleep sequencer
    // pulses default low, watchdog clear follows the clear instruction, then the state decides
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= SWC_RUN;
            cause_r <= SWC_CAUSE_NONE;
            prefetch_addr <= '0;
            prefetch_req <= 1'b0;
            watchdog_clear <= 1'b0;
            device_reset <= 1'b0;
            clk_run <= 1'b1;
            osc_drive <= 1'b1;
            port_hold <= 1'b0;
            resume <= 1'b0;
            vector_branch <= 1'b0;
            vector_addr <= `SWC_VECTOR_ADDR;
            time_out_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else begin
            prefetch_req <= 1'b0;
            watchdog_clear <= watchdog_clear_instruction;
            device_reset <= 1'b0;
            resume <= 1'b0;
            vector_branch <= 1'b0;
            unique case (state_r)
                SWC_RUN: begin
                    if (sleep_exec) begin
                        prefetch_addr <= pc + `SWC_PC_W'(1);
                        prefetch_req <= 1'b1;
                        if (!int_pend) begin
                            watchdog_clear <= 1'b1;
                            power_down_flag <= 1'b0;
                            time_out_flag <= 1'b1;
                            clk_run <= 1'b0;
                            osc_drive <= 1'b0;
                            port_hold <= 1'b1;
                            state_r <= SWC_ASLEEP;
                        end
                    end
                end
                SWC_ASLEEP: begin
                    if (!rst_pin_n_s || int_pend || (wdt_to_s && ctrl_r[`SWC_CTRL_WDT_EN])) begin
                        watchdog_clear <= 1'b1;
                        osc_drive <= 1'b1;
                        if (!rst_pin_n_s) begin
                            cause_r <= SWC_CAUSE_RESET;
                        end else if (int_pend) begin
                            cause_r <= SWC_CAUSE_INT;
                        end else begin
                            time_out_flag <= 1'b0;
                            cause_r <= SWC_CAUSE_WDT;
                        end
                        state_r <= ctrl_r[`SWC_CTRL_XTAL] ? SWC_STARTUP : SWC_RESUME;
                    end
                end
                SWC_STARTUP: begin
                    // oscillator settling, clock still gated off
                    if (ost_done) begin
                        state_r <= SWC_RESUME;
                    end
                end
                SWC_RESUME: begin
                    clk_run <= 1'b1;
                    port_hold <= 1'b0;
                    state_r <= SWC_RUN;
                    if (cause_r == SWC_CAUSE_RESET) begin
                        device_reset <= 1'b1;
                    end else begin
                        resume <= 1'b1;
                        vector_branch <= (cause_r == SWC_CAUSE_INT) && ctrl_r[`SWC_CTRL_GIE];
                    end
                end
            endcase
        end
    end

    // ==========================================
    // event capture, set beats clear
    always_comb begin
        evt_set = '0;
        evt_set[`SWC_EVT_WAKE_RST] = device_reset;
        evt_set[`SWC_EVT_WAKE_WDT] = resume && (cause_r == SWC_CAUSE_WDT);
        evt_set[`SWC_EVT_WAKE_INT] = resume && (cause_r == SWC_CAUSE_INT);
        evt_set[`SWC_EVT_SLEEP_NOP] = (state_r == SWC_RUN) && sleep_exec && int_pend;
        evt_set[`SWC_EVT_SLEPT] = (state_r == SWC_RUN) && sleep_exec && !int_pend;
    end

    // ==========================================
    // axi4-lite write channel, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped or misaligned gets slverr
                unique case (awaddr_r)
                    `SWC_CTRL_OFS, `SWC_WAKE_EN_OFS, `SWC_FLAGS_OFS, `SWC_SRC_CFG_OFS, `SWC_EVT_OFS,
                    `SWC_MASK_OFS: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // register writes; the status word is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `SWC_CTRL_RST;
            wake_en_r <= `SWC_WAKE_EN_RST;
            src_cfg_r <= `SWC_SRC_CFG_RST;
            mask_r <= '0;
            evt_r <= '0;
        end else begin
            // clear first, then set so a same-cycle event survives
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                unique case (awaddr_r)
                    `SWC_CTRL_OFS: ctrl_r <= 3'(merge(32'(ctrl_r), wdata_r, wstrb_r));
                    `SWC_WAKE_EN_OFS: wake_en_r <= `SWC_NSRC'(merge(32'(wake_en_r), wdata_r, wstrb_r));
                    `SWC_SRC_CFG_OFS: src_cfg_r <= 2'(merge(32'(src_cfg_r), wdata_r, wstrb_r));
                    `SWC_MASK_OFS: mask_r <= `SWC_NEVT'(merge(32'(mask_r), wdata_r, wstrb_r));
                    `SWC_EVT_OFS: evt_r <= (evt_r & ~(wdata_r[`SWC_NEVT-1:0] & {`SWC_NEVT{wstrb_r[0]}})) | evt_set;
                    default: evt_r <= evt_r | evt_set;
                endcase
                if (awaddr_r != `SWC_EVT_OFS) begin
                    evt_r <= evt_r | evt_set;
                end
            end else begin
                evt_r <= evt_r | evt_set;
            end
        end
    end

    // ==========================================
    // axi4-lite read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr)
                    `SWC_CTRL_OFS: s_axi_rdata <= 32'(ctrl_r);
                    `SWC_WAKE_EN_OFS: s_axi_rdata <= 32'(wake_en_r);
                    // live status: flags, state, pending sources
                    `SWC_FLAGS_OFS: s_axi_rdata <= 32'({src_s, state_r, power_down_flag, time_out_flag});
                    `SWC_SRC_CFG_OFS: s_axi_rdata <= 32'(src_cfg_r);
                    `SWC_EVT_OFS: s_axi_rdata <= 32'(evt_r);
                    `SWC_MASK_OFS: s_axi_rdata <= 32'(mask_r);
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================
    // level interrupt from unmasked sticky events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_r & mask_r);
        end
    end
endmodule // swc_sleep_wakeup

// ===== testbench/swc_chk_sva.sv
`timescale 1ns/1ns
`include "swc_defines.svh"
// ==========================================
// port-level checks of the sleep and wake sequencer
module swc_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_exec,
    input wire logic [`SWC_PC_W-1:0] pc,
    input wire logic [`SWC_PC_W-1:0] prefetch_addr,
    input wire logic watchdog_clear,
    input wire logic device_reset,
    input wire logic clk_run,
    input wire logic osc_drive,
    input wire logic port_hold,
    input wire logic resume,
    input wire logic vector_branch,
    input wire logic [`SWC_PC_W-1:0] vector_addr,
    input wire logic time_out_flag,
    input wire logic power_down_flag
);
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_prefetch; sleep_exec && clk_run |=> prefetch_addr == $past(pc) + 13'h0001; endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong");
    property p_entry; $fell(power_down_flag) |-> time_out_flag && watchdog_clear && !clk_run && port_hold; endproperty
    a_entry: assert property (p_entry) else $error("sleep entry outputs wrong");
    property p_vec; vector_branch |-> resume && vector_addr == `SWC_VECTOR_ADDR; endproperty
    a_vec: assert property (p_vec) else $error("vector branch without resume");
    property p_rst; device_reset |-> !resume && !vector_branch && clk_run; endproperty
    a_rst: assert property (p_rst) else $error("reset wake also resumed");
    property p_resume; resume |-> clk_run && osc_drive && !port_hold; endproperty
    a_resume: assert property (p_resume) else $error("resume with clock held");
    property p_restart; $rose(clk_run) |-> resume || device_reset; endproperty
    a_restart: assert property (p_restart) else $error("clock restarted without wake");
    property p_wake_clr; $rose(osc_drive) |-> watchdog_clear; endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake without watchdog clear");
    // fall-to-resume cycles, beyond a delay range
    logic [10:0] to_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || resume) begin
            to_cnt_r <= '0;
        end else if ($fell(time_out_flag) || to_cnt_r != '0) begin
            to_cnt_r <= to_cnt_r + 11'h001;
        end
    end
    property p_to_clr; to_cnt_r <= 11'h44C; endproperty
    a_to_clr: assert property (p_to_clr) else $error("time-out flag fell without wake");
    property p_osc_off; !osc_drive |-> !clk_run && port_hold; endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator off while running");
    c_vec: cover property (vector_branch);
    c_rst: cover property (device_reset);
    c_entry: cover property ($fell(power_down_flag));
endmodule // swc_chk

// ===== testbench/swc_src_model.sv
`timescale 1ns/1ns
// ==========================================
// far side: reset pin, watchdog and interrupt sources
module swc_src_model
    import swc_pkg::*;
#(
    parameter int WDT_PERIOD = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_req,
    input wire logic wdt_run,
    input wire logic wdt_kick,
    input wire swc_src_t src_req,
    output logic external_reset_pin_n,
    output logic watchdog_timeout,
    output swc_src_t src_flags
);
    int cnt_r = 0; // watchdog count
    // pin and source levels are asynchronous to the core
    assign external_reset_pin_n = !pin_req;
    assign src_flags = src_req;
    // watchdog restarts on every clear, so a missed clear shows up
    always @(posedge aclk) begin
        if (!aresetn || wdt_kick || !wdt_run) begin
            cnt_r <= 0;
        end else if (cnt_r < WDT_PERIOD) begin
            cnt_r <= cnt_r + 1;
        end
    end
    // time-out level holds until the next clear
    assign watchdog_timeout = (cnt_r == WDT_PERIOD);
endmodule // swc_src_model

// ===== testbench/testbench.sv
`timescale 1ns/1ns
`include "swc_defines.svh"
bind swc_sleep_wakeup swc_chk u_chk (.*);
// ==========================================
// bench top: bus master, sequencer pokes, sources
module testbench
    import swc_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic pin_req = 1'h0, wdt_run = 1'h0, sleep_exec = 1'h0, watchdog_clear_instruction = 1'h0;
    logic [`SWC_PC_W-1:0] pc = '0, prefetch_addr, vector_addr;
    swc_src_t src_req = '0, src_flags;
    logic external_reset_pin_n, watchdog_timeout, prefetch_req, watchdog_clear, device_reset;
    logic clk_run, osc_drive, port_hold, resume, vector_branch, time_out_flag, power_down_flag, irq;
    int error_cnt = 0, n_compared = 0, cyc = 0, n;
    logic [3:0] s; // {clear seen, reset, vector, resume}
    swc_sleep_wakeup DUT (.*);
    swc_src_model #(.WDT_PERIOD(64)) u_src (.aclk(aclk), .aresetn(aresetn), .pin_req(pin_req),
        .wdt_run(wdt_run), .wdt_kick(watchdog_clear), .src_req(src_req),
        .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout), .src_flags(src_flags));
    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // write: each channel released at its own handshake
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic aw = 1'h1;
        logic w = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // sleep instruction; returns once its first effects have settled
    task automatic sl(input logic [`SWC_PC_W-1:0] p);
        @(posedge aclk);
        sleep_exec <= 1'h1;
        pc <= p;
        @(posedge aclk);
        sleep_exec <= 1'h0;
        #1;
    endtask
    task automatic src(input logic [8:0] v);
        @(posedge aclk);
        src_req <= swc_src_t'(v);
    endtask
    // wait for a wake pulse, bounded against a dead design
    task automatic wake();
        n = 0;
        s = '0;
        while (!(resume || device_reset) && n < 1200) begin
            @(posedge aclk);
            #1;
            n++;
            s[3] = s[3] | watchdog_clear;
        end
        s[2:0] = {device_reset, vector_branch, resume};
    endtask
    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, error_cnt);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs();
        rd(`SWC_CTRL_OFS);
        chk("ctrl reset", 32'h0, d);
        rd(`SWC_FLAGS_OFS);
        chk("flags after power-up", 32'h3, d & 32'hF);
        rd(5'h18);
        chk("unmapped read resp", 32'h2, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
        wr(5'h1C, 32'hFF);
        chk("unmapped write resp", 32'h2, {30'h0, r});
        done("regs");
    endtask
    task automatic t_nop();
        wr(`SWC_WAKE_EN_OFS, 32'h20);
        src(9'h020);
        repeat (4) @(posedge aclk);
        watchdog_clear_instruction <= 1'h1;
        @(posedge aclk);
        watchdog_clear_instruction <= 1'h0;
        #1;
        chk("clear instruction", 32'h1, {31'h0, watchdog_clear});
        sl(13'h0100);
        chk("nop clear", 32'h0, {31'h0, watchdog_clear});
        chk("nop flags", 32'h3, {30'h0, power_down_flag, time_out_flag});
        chk("nop clock", 32'h1, {31'h0, clk_run});
        rd(`SWC_EVT_OFS);
        chk("nop event", 32'h8, d & 32'h8);
        src(9'h000);
        wr(`SWC_EVT_OFS, 32'h1F);
        done("nop");
    endtask
    task automatic t_int(input logic global_interrupt_enable);
        wr(`SWC_CTRL_OFS, {31'h0, global_interrupt_enable});
        wr(`SWC_WAKE_EN_OFS, 32'h40);
        sl(13'h0200);
        chk("prefetch", 32'h201, {19'h0, prefetch_addr});
        chk("prefetch req", 32'h1, {31'h0, prefetch_req});
        chk("entry flags", 32'h1, {30'h0, power_down_flag, time_out_flag});
        chk("entry clock", 32'h0, {31'h0, clk_run});
        src(9'h040);
        wake();
        chk("int wake", {28'h0, 2'h2, global_interrupt_enable, 1'h1}, {28'h0, s});
        chk("no delay", 32'h1, {31'h0, n <= 8});
        chk("vector", 32'h4, {19'h0, vector_addr});
        src(9'h000);
        wr(`SWC_CTRL_OFS, 32'h0);
        done("int");
    endtask
    task automatic t_gate();
        wr(`SWC_WAKE_EN_OFS, 32'h05);
        wr(`SWC_SRC_CFG_OFS, 32'h0);
        sl(13'h0300);
        src(9'h045);
        repeat (40) @(posedge aclk);
        #1;
        chk("gated sources", 32'h0, {31'h0, clk_run});
        src(9'h000);
        wr(`SWC_SRC_CFG_OFS, 32'h1);
        src(9'h001);
        wake();
        chk("async timer wake", 32'h9, {28'h0, s});
        src(9'h000);
        done("gate");
    endtask
    task automatic t_wdt();
        wr(`SWC_CTRL_OFS, 32'h2);
        wdt_run <= 1'h1;
        sl(13'h0400);
        wake();
        chk("watchdog wake", 32'h9, {28'h0, s});
        @(posedge aclk);
        #1;
        chk("time-out flag", 32'h0, {31'h0, time_out_flag});
        wdt_run <= 1'h0;
        wr(`SWC_CTRL_OFS, 32'h0);
        done("wdt");
    endtask
    task automatic t_pin();
        sl(13'h0500);
        @(posedge aclk);
        pin_req <= 1'h1;
        wake();
        chk("pin wake", 32'hC, {28'h0, s});
        @(posedge aclk);
        pin_req <= 1'h0;
        done("pin");
    endtask
    task automatic t_xtal();
        wr(`SWC_CTRL_OFS, 32'h4);
        sl(13'h0600);
        src(9'h001);
        wake();
        chk("xtal wake", 32'h9, {28'h0, s});
        chk("start-up wait", 32'h1, {31'h0, n >= 1024 && n <= 1040});
        src(9'h000);
        wr(`SWC_CTRL_OFS, 32'h0);
        done("xtal");
    endtask
    // unmasked wake event raises irq; w1c drops it
    task automatic t_irq();
        wr(`SWC_MASK_OFS, 32'h4);
        @(posedge aclk);
        #1;
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`SWC_EVT_OFS, 32'h4);
        @(posedge aclk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        done("irq");
    endtask
    // ==========================================
    // clock, timeout and closing report
    initial forever #2 aclk = ~aclk;
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_nop();
        t_int(1'h0);
        t_int(1'h1);
        t_gate();
        t_wdt();
        t_pin();
        t_xtal();
        t_irq();
        close_out();
    end
endmodule // testbench
